// [hw/ldd_defs.svh]
// Constants for the LED driver serial load and shutdown block
// How it works
// - Serial input shifts into a 16-bit shift register on each rising serial clock, in the select variant only while chip select is low.
// - Strobe variant shifts on every rising clock whatever the strobe level.
// - Select variant ignores serial clock entirely while chip select is high.
// - Rising strobe or chip select commits the last 16 bits to the addressed register.
// - A bit entering serial input leaves serial output 15.5 clocks after the rising edge that samples it.
// - Serial output changes on falling clock edges; input sampled on rising edges.
// - Serial output is always driven, never high impedance.
// - Frame bits 11..8 are the address, 7..0 data, 15..12 ignored.
// - Frames travel most significant bit first.
// - Fourteen registers; eight digit registers each writable alone.
// - Control registers: decode mode, brightness, scan limit, shutdown, display test.
// - Shutdown halts scanning and blanks every segment and digit unless display test is on.
// - Entering or leaving shutdown keeps all register contents.
// - Register writes are committed in shutdown exactly as in normal running.
// - Display test lights the display even during shutdown.
// - Display resumes within 250 us after shutdown is cleared.
// - Address 0 no-op, 1-8 digits, 9 decode, A brightness, B scan, C shutdown, F test.
// - Shutdown register bit 0 high runs normally, low shuts down.
// - After reset controls are cleared, display blank and in shutdown.
`ifndef LDD_DEFS_SVH
`define LDD_DEFS_SVH
`define LDD_FRAME_W 16
`define LDD_ADDR_MSB 11
`define LDD_ADDR_LSB 8
`define LDD_DATA_MSB 7
`define LDD_DIGITS 8
`define LDD_ADDR_NOOP 4'h0
`define LDD_ADDR_DIGIT0 4'h1
`define LDD_ADDR_DECODE 4'h9
`define LDD_ADDR_INTENS 4'ha
`define LDD_ADDR_SCAN 4'hb
`define LDD_ADDR_SHUT 4'hc
`define LDD_ADDR_TEST 4'hf
`define LDD_RST_DECODE 8'h00
`define LDD_RST_INTENS 4'h0
`define LDD_RST_SCAN 3'h0
`define LDD_RST_RUN 1'b0
`define LDD_RST_TEST 1'b0
`define LDD_CLK_MHZ 100
`define LDD_WAKE_US 250
`define LDD_WAKE_CYC (`LDD_WAKE_US * `LDD_CLK_MHZ)
`define LDD_WAKE_CNT_W 15
`endif

// [hw/ldd_pkg.sv]
// Types for the LED driver serial load and shutdown block
package ldd_pkg;
  typedef logic [3:0] ldd_addr_t;
  typedef logic [7:0] ldd_data_t;
  typedef enum logic [1:0] {
    LDD_OFF,
    LDD_WAKING,
    LDD_RUN
  } ldd_wake_t;
endpackage

// [hw/ldd_serial_load.sv]
// Serial front end, register file and shutdown control of the LED driver
`timescale 1ns/1ps
`include "ldd_defs.svh"
module ldd_serial_load
  import ldd_pkg::*;
#(
  parameter bit SEL_VARIANT = 1'b0,
  parameter int WAKE_CYCLES = `LDD_WAKE_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ser_clk,
  input wire logic serial_in,
  input wire logic latch_strobe,
  input wire logic chip_sel_n,
  output logic serial_out,
  output logic serial_out_oe,
  output logic [63:0] digit_regs,
  output logic [7:0] decode_mode,
  output logic [3:0] intensity,
  output logic [2:0] scan_limit,
  output logic shutdown_on,
  output logic display_test_on,
  output logic scan_run,
  output logic display_lit,
  output logic frame_commit
);

  // Link domain: shift register on the serial clock
  logic [`LDD_FRAME_W-1:0] shift_reg;
  logic sout_reg;
  logic shift_en;

  assign shift_en = SEL_VARIANT ? ~chip_sel_n : 1'b1;

  always_ff @(posedge ser_clk or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= '0;
    end else if (shift_en) begin
      shift_reg <= {shift_reg[`LDD_FRAME_W-2:0], serial_in};
    end
  end

  // Output half a cycle behind the last stage
  always_ff @(negedge ser_clk or negedge rstn) begin
    if (!rstn) begin
      sout_reg <= 1'b0;
    end else if (shift_en) begin
      sout_reg <= shift_reg[`LDD_FRAME_W-1];
    end
  end

  assign serial_out = sout_reg;
  assign serial_out_oe = 1'b1;

  // System domain: commit edge detection
  logic commit_lvl;
  logic cm_s1_reg;
  logic cm_s2_reg;
  logic cm_s3_reg;
  logic commit_pulse;

  // Reset to the pin's idle level, or a select held high fakes a commit
  localparam logic CM_IDLE = SEL_VARIANT;

  assign commit_lvl = SEL_VARIANT ? chip_sel_n : latch_strobe;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cm_s1_reg <= CM_IDLE;
      cm_s2_reg <= CM_IDLE;
      cm_s3_reg <= CM_IDLE;
    end else begin
      cm_s1_reg <= commit_lvl;
      cm_s2_reg <= cm_s1_reg;
      cm_s3_reg <= cm_s2_reg;
    end
  end

  assign commit_pulse = cm_s2_reg & ~cm_s3_reg;

  // Frame word is quiet while the strobe edge is handled
  logic [`LDD_FRAME_W-1:0] frame_reg;
  logic frame_vld_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frame_reg <= '0;
    end else if (commit_pulse) begin
      frame_reg <= shift_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frame_vld_reg <= 1'b0;
    end else begin
      frame_vld_reg <= commit_pulse;
    end
  end

  assign frame_commit = frame_vld_reg;

  ldd_addr_t wr_addr;
  ldd_data_t wr_data;

  assign wr_addr = frame_reg[`LDD_ADDR_MSB:`LDD_ADDR_LSB];
  assign wr_data = frame_reg[`LDD_DATA_MSB:0];

  // Digit storage, one entry per digit
  logic [7:0] digit_mem_reg [`LDD_DIGITS];

  genvar gi;
  generate
    for (gi = 0; gi < `LDD_DIGITS; gi++) begin : g_digit
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          digit_mem_reg[gi] <= 8'h00;
        end else if (frame_vld_reg && wr_addr == `LDD_ADDR_DIGIT0 + 4'(gi)) begin
          digit_mem_reg[gi] <= wr_data;
        end
      end
      assign digit_regs[gi*8 +: 8] = digit_mem_reg[gi];
    end
  endgenerate

  // Control registers
  logic [7:0] decode_reg;
  logic [3:0] intens_reg;
  logic [2:0] scan_reg;
  logic run_reg;
  logic test_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      decode_reg <= `LDD_RST_DECODE;
      intens_reg <= `LDD_RST_INTENS;
      scan_reg <= `LDD_RST_SCAN;
      run_reg <= `LDD_RST_RUN;
      test_reg <= `LDD_RST_TEST;
    end else if (frame_vld_reg) begin
      unique case (wr_addr)
        `LDD_ADDR_DECODE: begin
          decode_reg <= wr_data;
        end
        `LDD_ADDR_INTENS: begin
          intens_reg <= wr_data[3:0];
        end
        `LDD_ADDR_SCAN: begin
          scan_reg <= wr_data[2:0];
        end
        `LDD_ADDR_SHUT: begin
          run_reg <= wr_data[0];
        end
        `LDD_ADDR_TEST: begin
          test_reg <= wr_data[0];
        end
        default: begin
        end
      endcase
    end
  end

  assign decode_mode = decode_reg;
  assign intensity = intens_reg;
  assign scan_limit = scan_reg;
  assign shutdown_on = ~run_reg;
  assign display_test_on = test_reg;

  // Scan oscillator wake-up after leaving shutdown
  ldd_wake_t wake_reg;
  logic [`LDD_WAKE_CNT_W-1:0] wake_cnt_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wake_reg <= LDD_OFF;
      wake_cnt_reg <= '0;
    end else if (!run_reg) begin
      wake_reg <= LDD_OFF;
      wake_cnt_reg <= '0;
    end else begin
      unique case (wake_reg)
        LDD_OFF: begin
          wake_reg <= LDD_WAKING;
        end
        LDD_WAKING: begin
          if (wake_cnt_reg >= `LDD_WAKE_CNT_W'(WAKE_CYCLES - 2)) begin
            wake_reg <= LDD_RUN;
          end else begin
            wake_cnt_reg <= wake_cnt_reg + 1'b1;
          end
        end
        LDD_RUN: begin
          wake_reg <= LDD_RUN;
        end
      endcase
    end
  end

  // Gated by the run bit so shutdown blanks on the very next cycle
  assign scan_run = test_reg | (run_reg && wake_reg == LDD_RUN);
  assign display_lit = test_reg | (run_reg && wake_reg == LDD_RUN);

  // Link-domain checks
  property p_shift_in;
    @(posedge ser_clk) disable iff (!rstn)
      shift_en |=> shift_reg[0] == $past(serial_in) &&
        shift_reg[15:1] == $past(shift_reg[14:0]);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("Shift register did not take serial input");

  property p_strobe_free;
    @(posedge ser_clk) disable iff (!rstn)
      (!SEL_VARIANT && latch_strobe) |=> shift_reg[0] == $past(serial_in);
  endproperty
  a_strobe_free: assert property (p_strobe_free)
    else $error("Shift stalled by strobe level");

  property p_cs_hold;
    @(posedge ser_clk) disable iff (!rstn)
      (SEL_VARIANT && chip_sel_n) |=> $stable(shift_reg);
  endproperty
  a_cs_hold: assert property (p_cs_hold)
    else $error("Shifted while chip select high");

  property p_sout_half;
    @(posedge ser_clk) disable iff (!rstn)
      (shift_en && $past(shift_en)) |-> serial_out == shift_reg[15];
  endproperty
  a_sout_half: assert property (p_sout_half)
    else $error("Serial output not last stage on falling edge");

  property p_sout_quiet;
    @(negedge ser_clk) disable iff (!rstn)
      (SEL_VARIANT && chip_sel_n) |=> $stable(serial_out);
  endproperty
  a_sout_quiet: assert property (p_sout_quiet)
    else $error("Serial output moved while deselected");

  property p_oe;
    @(posedge sys_clk) disable iff (!rstn)
      serial_out_oe;
  endproperty
  a_oe: assert property (p_oe)
    else $error("Serial output released");

  // System-domain checks
  property p_commit_take;
    @(posedge sys_clk) disable iff (!rstn)
      commit_pulse |=> frame_commit ##1 !frame_commit;
  endproperty
  a_commit_take: assert property (p_commit_take)
    else $error("Commit pulse not one cycle");

  property p_digit_write;
    @(posedge sys_clk) disable iff (!rstn)
      (frame_commit && wr_addr == 4'h3) |=>
        digit_regs[23:16] == $past(wr_data) &&
        digit_regs[15:0] == $past(digit_regs[15:0]) &&
        digit_regs[63:24] == $past(digit_regs[63:24]);
  endproperty
  a_digit_write: assert property (p_digit_write)
    else $error("Digit write wrong or disturbed others");

  property p_noop;
    @(posedge sys_clk) disable iff (!rstn)
      (frame_commit && wr_addr == `LDD_ADDR_NOOP) |=>
        $stable(digit_regs) && $stable(decode_mode) && $stable(intensity) &&
        $stable(scan_limit) && $stable(shutdown_on) && $stable(display_test_on);
  endproperty
  a_noop: assert property (p_noop)
    else $error("No-op frame changed a register");

  property p_blank;
    @(posedge sys_clk) disable iff (!rstn)
      (shutdown_on && !display_test_on) |-> !display_lit && !scan_run;
  endproperty
  a_blank: assert property (p_blank)
    else $error("Display lit in shutdown");

  property p_keep;
    @(posedge sys_clk) disable iff (!rstn)
      $changed(shutdown_on) |-> $stable(digit_regs) && $stable(decode_mode) &&
        $stable(intensity) && $stable(scan_limit);
  endproperty
  a_keep: assert property (p_keep)
    else $error("Shutdown change altered registers");

  property p_shut_write;
    @(posedge sys_clk) disable iff (!rstn)
      (shutdown_on && frame_commit && wr_addr == `LDD_ADDR_INTENS) |=>
        intensity == $past(wr_data[3:0]);
  endproperty
  a_shut_write: assert property (p_shut_write)
    else $error("Write lost during shutdown");

  property p_test_prio;
    @(posedge sys_clk) disable iff (!rstn)
      display_test_on |-> display_lit;
  endproperty
  a_test_prio: assert property (p_test_prio)
    else $error("Display test not lighting");

  property p_wake;
    @(posedge sys_clk) disable iff (!rstn)
      (wake_reg == LDD_WAKING && !shutdown_on) |->
        wake_cnt_reg <= `LDD_WAKE_CNT_W'(WAKE_CYCLES - 2);
  endproperty
  a_wake: assert property (p_wake)
    else $error("Wake-up exceeds limit");

  property p_shut_bit;
    @(posedge sys_clk) disable iff (!rstn)
      (frame_commit && wr_addr == `LDD_ADDR_SHUT) |=>
        shutdown_on == !$past(wr_data[0]);
  endproperty
  a_shut_bit: assert property (p_shut_bit)
    else $error("Shutdown bit decode wrong");

  property p_frame_take;
    @(posedge sys_clk) disable iff (!rstn)
      commit_pulse |=> frame_reg == $past(shift_reg);
  endproperty
  a_frame_take: assert property (p_frame_take)
    else $error("Committed frame differs from shift register");

  property p_decode_write;
    @(posedge sys_clk) disable iff (!rstn)
      (frame_commit && wr_addr == `LDD_ADDR_DECODE) |=> decode_mode == $past(wr_data);
  endproperty
  a_decode_write: assert property (p_decode_write)
    else $error("Decode mode write wrong");

  property p_wake_start;
    @(posedge sys_clk) disable iff (!rstn)
      (run_reg && wake_reg == LDD_OFF) |=> wake_reg == LDD_WAKING;
  endproperty
  a_wake_start: assert property (p_wake_start)
    else $error("Oscillator did not start after shutdown cleared");

  // Main scenarios
  c_digit: cover property (@(posedge sys_clk) disable iff (!rstn)
    frame_commit && wr_addr == `LDD_ADDR_DIGIT0);
  c_leave_shut: cover property (@(posedge sys_clk) disable iff (!rstn)
    $rose(scan_run) && !display_test_on);
  c_test_shut: cover property (@(posedge sys_clk) disable iff (!rstn)
    display_test_on && shutdown_on);
  c_noop: cover property (@(posedge sys_clk) disable iff (!rstn)
    frame_commit && wr_addr == `LDD_ADDR_NOOP);
  c_sel_refuse: cover property (@(posedge ser_clk) disable iff (!rstn)
    SEL_VARIANT && chip_sel_n);

endmodule // ldd_serial_load

// [bench/ldd_host_model.sv]
// Host serial controller model that shifts frames into the driver
`timescale 1ns/1ps
module ldd_host_model #(
  parameter int HALF_NS = 24
) (
  output logic ser_clk,
  output logic serial_in,
  output logic latch_strobe,
  output logic chip_sel_n
);
  initial begin
    ser_clk = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
    chip_sel_n = 1'b1;
  end

  task automatic send(input logic [15:0] frame, input int stray);
    // Clocks while deselected: strobe variant shifts them, select variant must not
    for (int k = 0; k < stray; k++) begin
      serial_in = frame[k];
      #(HALF_NS);
      ser_clk = 1'b1;
      #(HALF_NS);
      ser_clk = 1'b0;
    end
    #(HALF_NS / 2);
    latch_strobe = 1'b0;
    chip_sel_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_in = frame[i];
      #(HALF_NS);
      ser_clk = 1'b1;
      #(HALF_NS);
      ser_clk = 1'b0;
    end
    // Select held past the last falling edge so the chain output still moves
    #(HALF_NS / 2);
    // Released data line must not keep showing the last bit
    serial_in = ~frame[0];
    // Strobe stays high into the next stray clocks
    latch_strobe = 1'b1;
    chip_sel_n = 1'b1;
    #120;
  endtask
endmodule // ldd_host_model

// [bench/led_driver_serial_load_and_shutdown_tb.sv]
// Self-checking bench for the LED driver serial load and shutdown block
`timescale 1ns/1ps
module led_driver_serial_load_and_shutdown_tb;
  import ldd_pkg::*;
  localparam int WAKE = 8;
  logic sys_clk, rstn, ser_clk, serial_in, latch_strobe, chip_sel_n;
  logic serial_out, serial_out_oe, shutdown_on, display_test_on, scan_run, display_lit;
  logic frame_commit;
  logic [63:0] digit_regs;
  logic [7:0] decode_mode;
  logic [3:0] intensity;
  logic [2:0] scan_limit;
  logic cs_serial_out, cs_serial_out_oe, cs_shutdown_on, cs_display_test_on, cs_scan_run;
  logic cs_display_lit, cs_frame_commit;
  logic [63:0] cs_digit_regs;
  logic [7:0] cs_decode_mode;
  logic [3:0] cs_intensity;
  logic [2:0] cs_scan_limit;
  int commits_cs = 0;
  logic [15:0] m_sr_cs = 16'h0000;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int commits = 0;
  int frames = 0;
  logic [31:0] seed = 32'haab71078;
  logic [31:0] r;
  logic [7:0] m_dig [8];
  logic [7:0] m_dec = 8'h00;
  logic [3:0] m_int = 4'h0;
  logic [2:0] m_scan = 3'h0;
  logic m_run = 1'b0;
  logic m_test = 1'b0;
  logic [15:0] m_sr = 16'h0000;
  logic [3:0] noop [3] = '{4'h0, 4'hd, 4'he};

  ldd_serial_load #(.SEL_VARIANT(1'b0), .WAKE_CYCLES(WAKE)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .ser_clk(ser_clk), .serial_in(serial_in),
    .latch_strobe(latch_strobe), .chip_sel_n(chip_sel_n), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .digit_regs(digit_regs), .decode_mode(decode_mode),
    .intensity(intensity), .scan_limit(scan_limit), .shutdown_on(shutdown_on),
    .display_test_on(display_test_on), .scan_run(scan_run), .display_lit(display_lit),
    .frame_commit(frame_commit));

  // Select variant on the same link: must ignore clocks while deselected
  ldd_serial_load #(.SEL_VARIANT(1'b1), .WAKE_CYCLES(WAKE)) dut_cs (
    .sys_clk(sys_clk), .rstn(rstn), .ser_clk(ser_clk), .serial_in(serial_in),
    .latch_strobe(latch_strobe), .chip_sel_n(chip_sel_n), .serial_out(cs_serial_out),
    .serial_out_oe(cs_serial_out_oe), .digit_regs(cs_digit_regs),
    .decode_mode(cs_decode_mode), .intensity(cs_intensity), .scan_limit(cs_scan_limit),
    .shutdown_on(cs_shutdown_on), .display_test_on(cs_display_test_on),
    .scan_run(cs_scan_run), .display_lit(cs_display_lit), .frame_commit(cs_frame_commit));

  ldd_host_model host (.ser_clk(ser_clk), .serial_in(serial_in),
    .latch_strobe(latch_strobe), .chip_sel_n(chip_sel_n));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check1(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic check_regs();
    logic [63:0] d;
    for (int i = 0; i < 8; i++) d[8*i +: 8] = m_dig[i];
    check1(digit_regs === d, "digit registers");
    check1(decode_mode === m_dec && intensity === m_int, "decode or intensity");
    check1(scan_limit === m_scan, "scan limit");
    check1(shutdown_on === !m_run && display_test_on === m_test, "mode bits");
    check1(display_lit === (m_test | m_run), "display lit");
    check1(scan_run === (m_test | m_run), "scan run");
    check1(commits === frames, "commit count");
    check1(cs_digit_regs === d && cs_decode_mode === m_dec, "cs digits");
    check1(cs_intensity === m_int && cs_scan_limit === m_scan, "cs controls");
    check1(cs_shutdown_on === !m_run && cs_display_test_on === m_test, "cs modes");
    check1(cs_display_lit === (m_test | m_run), "cs display lit");
    check1(cs_scan_run === (m_test | m_run), "cs scan run");
    check1(commits_cs === frames, "cs commit count");
  endtask

  task automatic write(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] t;
    t = rnd();
    host.send({t[3:0], a, d}, int'(t[5:4]));
    frames++;
    case (a)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: m_dig[a - 4'h1] = d;
      4'h9: m_dec = d;
      4'ha: m_int = d[3:0];
      4'hb: m_scan = d[2:0];
      4'hc: m_run = d[0];
      4'hf: m_test = d[0];
      default: ;
    endcase
    repeat (WAKE + 12) @(negedge sys_clk);
    check_regs();
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (frame_commit === 1'b1) commits++;
    if (cs_frame_commit === 1'b1) commits_cs++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  always @(posedge ser_clk) m_sr <= {m_sr[14:0], serial_in};
  always @(posedge ser_clk) if (!chip_sel_n) m_sr_cs <= {m_sr_cs[14:0], serial_in};

  always @(negedge ser_clk) begin
    #2;
    check1(serial_out === m_sr[15] && serial_out_oe === 1'b1, "serial out");
    check1(cs_serial_out === m_sr_cs[15], "cs serial out");
    check1(cs_serial_out_oe === 1'b1, "cs output enable");
  end

  initial begin
    foreach (m_dig[i]) m_dig[i] = 8'h00;
    rstn = 1'b0;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    check_regs();
    $display("test reset done");
    for (int i = 1; i <= 8; i++) begin
      r = rnd();
      write(i[3:0], r[7:0]);
    end
    $display("test digits done");
    write(4'h9, 8'ha5);
    write(4'ha, 8'hf3);
    write(4'hb, 8'hfe);
    write(4'hc, 8'h01);
    write(4'hf, 8'h01);
    write(4'hc, 8'hfe);
    write(4'hf, 8'h00);
    write(4'h3, 8'h5c);
    write(4'hc, 8'h01);
    $display("test shutdown done");
    foreach (noop[i]) write(noop[i], 8'hff);
    $display("test no-op done");
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      write(r[11:8], r[7:0]);
    end
    $display("test random done");
    wrap_up();
  end
endmodule // led_driver_serial_load_and_shutdown_tb
